// ===== hdl/usbi_in_ep_ctrl.sv
// IN endpoint 1-3 low control and status byte with token response logic
// ****************************************
// ****************************************
//
// The implementer's own choices: the strobed register port and the address map.
module usbi_in_ep_ctrl
  import usbi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_token,
  input wire logic [EP_W-1:0] i_token_ep,
  input wire logic i_ack,
  input wire logic [EP_W-1:0] i_ack_ep,
  output logic o_resp_valid,
  output logic [1:0] o_resp_kind,
  output logic o_resp_toggle,
  output logic [EP_W-1:0] o_resp_ep,
  output logic o_irq
);
  typedef struct packed {
    logic [EP_W-1:0] index;
    logic [NUM_EP-1:0] toggle;
    logic [NUM_EP-1:0] stall_sent;
    logic [NUM_EP-1:0] send_stall;
    logic [NUM_EP-1:0] flush;
    logic [NUM_EP-1:0] underrun;
    logic [NUM_EP-1:0] pkt_rdy;
    logic [NUM_EP-1:0] dbl_buf;
    logic [NUM_EP-1:0] iso;
    logic [NUM_EP-1:0] int_stat;
    logic [NUM_EP-1:0] int_mask;
    logic [7:0] rdata;
    logic resp_valid;
    logic [1:0] resp_kind;
    logic resp_toggle;
    logic [EP_W-1:0] resp_ep;
  } usbi_state_t;

  usbi_state_t q_ff;
  usbi_state_t nxt_q;
  logic [NUM_EP-1:0] push;
  logic [NUM_EP-1:0] pop;
  logic [1:0] count [NUM_EP];

  // Endpoint number 1..3 to slot index, valid flag in top bit
  function automatic logic [EP_W:0] ep_slot(input logic [EP_W-1:0] ep);
    logic [EP_W:0] r;
    r = '0;
    if (ep != '0) begin
      r = {1'b1, EP_W'(ep - EP_W'(1))};
    end
    return r;
  endfunction

  function automatic logic [1:0] cap_of(input logic dbl);
    return dbl ? SLOTS_DOUBLE : SLOTS_SINGLE;
  endfunction

  // ****************************************
  // Packet slot counters
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++) begin : gen_slots
      usbi_pkt_slots #(
        .DEPTH(SLOTS_DOUBLE)
      ) u_slots (
        .i_clk(i_clk),
        .i_srst(i_srst),
        .i_push(push[g]),
        .i_pop(pop[g]),
        .o_count(count[g])
      );
    end
  endgenerate

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic [EP_W:0] sel;
    logic [EP_W:0] tok;
    logic [EP_W:0] ack;
    logic [1:0] cnt;
    logic [7:0] ctrl;
    logic [NUM_EP-1:0] flush_req;
    nxt_q = q_ff;
    push = '0;
    pop = '0;
    flush_req = '0;
    sel = ep_slot(q_ff.index);
    tok = ep_slot(i_token_ep);
    ack = ep_slot(i_ack_ep);
    cnt = SLOTS_NONE;
    ctrl = REG_RESET;
    nxt_q.resp_valid = 1'b0;
    nxt_q.rdata = REG_RESET;
    // Register read, answer stands one cycle
    if (i_rd) begin
      case (i_addr)
        ADDR_INDEX: nxt_q.rdata = 8'(q_ff.index);
        ADDR_CTRL_LOW: begin
          if (sel[EP_W]) begin
            ctrl[BIT_UNUSED_TOP] = 1'b0;
            ctrl[BIT_TOGGLE_CLEAR] = 1'b0;
            ctrl[BIT_STALL_SENT] = q_ff.stall_sent[sel[EP_W-1:0]];
            ctrl[BIT_SEND_STALL] = q_ff.send_stall[sel[EP_W-1:0]];
            ctrl[BIT_FLUSH] = q_ff.flush[sel[EP_W-1:0]];
            ctrl[BIT_UNDERRUN] = q_ff.underrun[sel[EP_W-1:0]];
            ctrl[BIT_FIFO_NE] = count[sel[EP_W-1:0]] != SLOTS_NONE;
            ctrl[BIT_IN_PKT_RDY] = q_ff.pkt_rdy[sel[EP_W-1:0]];
          end
          nxt_q.rdata = ctrl;
        end
        ADDR_CONFIG: begin
          if (sel[EP_W]) begin
            ctrl[BIT_DBL_BUF] = q_ff.dbl_buf[sel[EP_W-1:0]];
            ctrl[BIT_ISO] = q_ff.iso[sel[EP_W-1:0]];
          end
          nxt_q.rdata = ctrl;
        end
        ADDR_INT_STAT: nxt_q.rdata = 8'(q_ff.int_stat);
        ADDR_INT_MASK: nxt_q.rdata = 8'(q_ff.int_mask);
        default: nxt_q.rdata = REG_RESET;
      endcase
    end
    // Register write
    if (i_wr) begin
      case (i_addr)
        ADDR_INDEX: nxt_q.index = i_wdata[EP_W-1:0];
        ADDR_CTRL_LOW: begin
          if (sel[EP_W]) begin
            if (i_wdata[BIT_TOGGLE_CLEAR]) begin
              nxt_q.toggle[sel[EP_W-1:0]] = 1'b0;
            end
            if (!i_wdata[BIT_STALL_SENT]) begin
              nxt_q.stall_sent[sel[EP_W-1:0]] = 1'b0;
            end
            nxt_q.send_stall[sel[EP_W-1:0]] = i_wdata[BIT_SEND_STALL];
            if (i_wdata[BIT_FLUSH]) begin
              nxt_q.flush[sel[EP_W-1:0]] = 1'b1;
              flush_req[sel[EP_W-1:0]] = 1'b1;
            end
            if (!i_wdata[BIT_UNDERRUN]) begin
              nxt_q.underrun[sel[EP_W-1:0]] = 1'b0;
            end
            cnt = count[sel[EP_W-1:0]];
            if (i_wdata[BIT_IN_PKT_RDY] && !q_ff.pkt_rdy[sel[EP_W-1:0]] &&
                cnt < cap_of(q_ff.dbl_buf[sel[EP_W-1:0]])) begin
              push[sel[EP_W-1:0]] = 1'b1;
              // Keep ready only while the packet holds the last open slot
              nxt_q.pkt_rdy[sel[EP_W-1:0]] =
                (cnt + SLOT_ONE) >= cap_of(q_ff.dbl_buf[sel[EP_W-1:0]]);
            end
          end
        end
        ADDR_CONFIG: begin
          if (sel[EP_W]) begin
            nxt_q.dbl_buf[sel[EP_W-1:0]] = i_wdata[BIT_DBL_BUF];
            nxt_q.iso[sel[EP_W-1:0]] = i_wdata[BIT_ISO];
          end
        end
        ADDR_INT_STAT: nxt_q.int_stat = q_ff.int_stat & ~i_wdata[NUM_EP-1:0];
        ADDR_INT_MASK: nxt_q.int_mask = i_wdata[NUM_EP-1:0];
        default: ;
      endcase
    end
    // Pending flushes, one packet per request
    for (int e = 0; e < NUM_EP; e++) begin
      if (q_ff.flush[e]) begin
        // Back to back request stays queued for the next packet
        nxt_q.flush[e] = flush_req[e];
        nxt_q.pkt_rdy[e] = 1'b0;
        if (count[e] != SLOTS_NONE) begin
          pop[e] = 1'b1;
          nxt_q.int_stat[e] = 1'b1;
        end
      end
    end
    // IN token answer
    if (i_token && tok[EP_W]) begin
      nxt_q.resp_valid = 1'b1;
      nxt_q.resp_ep = i_token_ep;
      nxt_q.resp_toggle = q_ff.toggle[tok[EP_W-1:0]];
      if (q_ff.send_stall[tok[EP_W-1:0]]) begin
        nxt_q.resp_kind = RESP_STALL;
        nxt_q.stall_sent[tok[EP_W-1:0]] = 1'b1;
        nxt_q.pkt_rdy[tok[EP_W-1:0]] = 1'b0;
        nxt_q.int_stat[tok[EP_W-1:0]] = 1'b1;
      end else if (count[tok[EP_W-1:0]] != SLOTS_NONE) begin
        nxt_q.resp_kind = RESP_DATA;
        pop[tok[EP_W-1:0]] = 1'b1;
        nxt_q.pkt_rdy[tok[EP_W-1:0]] = 1'b0;
        if (q_ff.iso[tok[EP_W-1:0]]) begin
          nxt_q.int_stat[tok[EP_W-1:0]] = 1'b1;
        end
      end else if (q_ff.iso[tok[EP_W-1:0]]) begin
        nxt_q.resp_kind = RESP_ZLP;
        nxt_q.underrun[tok[EP_W-1:0]] = 1'b1;
      end else begin
        nxt_q.resp_kind = RESP_NAK;
      end
    end
    // Host ACK completes a bulk or interrupt transfer
    if (i_ack && ack[EP_W] && !q_ff.iso[ack[EP_W-1:0]]) begin
      nxt_q.toggle[ack[EP_W-1:0]] = ~q_ff.toggle[ack[EP_W-1:0]];
      nxt_q.int_stat[ack[EP_W-1:0]] = 1'b1;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_rdata = q_ff.rdata;
  assign o_resp_valid = q_ff.resp_valid;
  assign o_resp_kind = q_ff.resp_kind;
  assign o_resp_toggle = q_ff.resp_toggle;
  assign o_resp_ep = q_ff.resp_ep;
  assign o_irq = |(q_ff.int_stat & q_ff.int_mask);
endmodule

// ===== hdl/usbi_pkg.sv
// Constants and types shared by the IN endpoint control block
package usbi_pkg;
  localparam int NUM_EP = 3;
  localparam int EP_W = 2;
  // ****************************************
  // Register addresses
  // ****************************************
  localparam logic [2:0] ADDR_INDEX = 3'h0;
  localparam logic [2:0] ADDR_CTRL_LOW = 3'h1;
  localparam logic [2:0] ADDR_CONFIG = 3'h2;
  localparam logic [2:0] ADDR_INT_STAT = 3'h3;
  localparam logic [2:0] ADDR_INT_MASK = 3'h4;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_UNUSED_TOP = 7;
  localparam int BIT_TOGGLE_CLEAR = 6;
  localparam int BIT_STALL_SENT = 5;
  localparam int BIT_SEND_STALL = 4;
  localparam int BIT_FLUSH = 3;
  localparam int BIT_UNDERRUN = 2;
  localparam int BIT_FIFO_NE = 1;
  localparam int BIT_IN_PKT_RDY = 0;
  localparam int BIT_DBL_BUF = 7;
  localparam int BIT_ISO = 6;
  // ****************************************
  // Reset values and slot counts
  // ****************************************
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] SLOTS_SINGLE = 2'h1;
  localparam logic [1:0] SLOTS_DOUBLE = 2'h2;
  localparam logic [1:0] SLOTS_NONE = 2'h0;
  localparam logic [1:0] SLOT_ONE = 2'h1;
  typedef enum logic [1:0] {
    RESP_NAK,
    RESP_DATA,
    RESP_ZLP,
    RESP_STALL
  } usbi_resp_t;
endpackage

// ===== hdl/usbi_pkt_slots.sv
// Packet slot counter for one IN endpoint FIFO
module usbi_pkt_slots
  import usbi_pkg::*;
#(
  parameter logic [1:0] DEPTH = SLOTS_DOUBLE
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_push,
  input wire logic i_pop,
  output logic [1:0] o_count
);
  typedef struct packed {
    logic [1:0] count;
  } usbi_slot_state_t;

  usbi_slot_state_t q_ff;
  usbi_slot_state_t nxt_q;

  always_comb begin
    nxt_q = q_ff;
    if (i_push && !i_pop && q_ff.count < DEPTH) begin
      nxt_q.count = q_ff.count + SLOT_ONE;
    end else if (i_pop && !i_push && q_ff.count != SLOTS_NONE) begin
      nxt_q.count = q_ff.count - SLOT_ONE;
    end else if (i_pop && i_push && q_ff.count == SLOTS_NONE) begin
      nxt_q.count = SLOT_ONE;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign o_count = q_ff.count;
endmodule

// ===== tb/usbi_monitor.sv
// Port checks for the IN endpoint control block
module usbi_monitor
  import usbi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_token,
  input wire logic [EP_W-1:0] i_token_ep,
  input wire logic i_ack,
  input wire logic [EP_W-1:0] i_ack_ep,
  input wire logic o_resp_valid,
  input wire logic [1:0] o_resp_kind,
  input wire logic o_resp_toggle,
  input wire logic [EP_W-1:0] o_resp_ep,
  input wire logic o_irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_srst);
  sequence s_tok;
    i_token && i_token_ep != 2'h0;
  endsequence
  sequence s_ctrl_rd;
    i_rd && i_addr == ADDR_CTRL_LOW;
  endsequence
  sequence s_flush_wr;
    i_wr && i_addr == ADDR_CTRL_LOW && i_wdata[BIT_FLUSH];
  endsequence
  a_tok_answered: assert property (s_tok |=> o_resp_valid && o_resp_ep == $past(i_token_ep))
    else $error("token without answer");
  a_no_spurious: assert property (!(i_token && i_token_ep != 2'h0) |=> !o_resp_valid)
    else $error("answer without token");
  a_kind_held: assert property (!o_resp_valid |-> $stable(o_resp_kind))
    else $error("answer kind moved");
  a_toggle_held: assert property (!o_resp_valid |-> $stable(o_resp_toggle))
    else $error("answer toggle moved");
  a_top_bit_zero: assert property (s_ctrl_rd |=> !o_rdata[BIT_UNUSED_TOP])
    else $error("top bit read one");
  a_clr_reads_zero: assert property (s_ctrl_rd |=> !o_rdata[BIT_TOGGLE_CLEAR])
    else $error("toggle clear read one");
  a_flush_self_clear: assert property (s_flush_wr ##1 !i_wr ##1 s_ctrl_rd |=> !o_rdata[BIT_FLUSH])
    else $error("flush bit stuck");
  a_mask_off_irq: assert property (i_wr && i_addr == ADDR_INT_MASK && i_wdata[2:0] == 3'h0 |=> !o_irq)
    else $error("masked interrupt high");
endmodule
bind usbi_in_ep_ctrl usbi_monitor i_mon (.*);

// ===== tb/usbi_host_model.sv
// Host side: issues IN tokens and acknowledges data packets
module usbi_host_model
  import usbi_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_go,
  input wire logic [EP_W-1:0] i_ep,
  input wire logic i_resp_valid,
  input wire logic [1:0] i_resp_kind,
  input wire logic [EP_W-1:0] i_resp_ep,
  output logic o_token,
  output logic [EP_W-1:0] o_token_ep,
  output logic o_ack,
  output logic [EP_W-1:0] o_ack_ep
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_token = 1'b0;
    o_token_ep = 2'h0;
    o_ack = 1'b0;
    o_ack_ep = 2'h0;
  end
  // Idle endpoint lines change every cycle
  always @(posedge i_clk) begin
    o_token <= i_go;
    o_token_ep <= i_go ? i_ep : ~o_token_ep;
    o_ack <= i_resp_valid && i_resp_kind == RESP_DATA;
    o_ack_ep <= i_resp_valid ? i_resp_ep : ~o_ack_ep;
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for the IN endpoint control block
module testbench
  import usbi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [1:0] ep;
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [1:0] kind;
    logic [7:0] rb;
  } usbi_row_t;
  usbi_row_t rows [4] = '{'{2'h1, 8'h00, 8'h00, RESP_NAK, 8'h00},
    '{2'h2, 8'h00, 8'h01, RESP_DATA, 8'h00}, '{2'h3, 8'h40, 8'h00, RESP_ZLP, 8'h04},
    '{2'h1, 8'h00, 8'h10, RESP_STALL, 8'h30}};
  logic i_clk = 0, i_srst = 1, i_wr = 0, i_rd = 0, go = 0;
  logic i_token, i_ack, o_resp_valid, o_resp_toggle, o_irq;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata;
  logic [1:0] ep = 2'h0, i_token_ep, i_ack_ep, o_resp_ep, o_resp_kind;
  int err_count = 0, n_checks = 0, cyc = 0;
  always #2.5 i_clk = ~i_clk;
  usbi_in_ep_ctrl i_usbi_in_ep_ctrl (.*);
  usbi_host_model i_usbi_host_model (.i_clk(i_clk), .i_go(go), .i_ep(ep),
    .i_resp_valid(o_resp_valid), .i_resp_kind(o_resp_kind), .i_resp_ep(o_resp_ep),
    .o_token(i_token), .o_token_ep(i_token_ep), .o_ack(i_ack), .o_ack_ep(i_ack_ep));
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_count++;
      final_report();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] exp, input logic [7:0] m = 8'hff);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1 chk(o_rdata & m, exp);
  endtask
  task automatic tok(input logic [1:0] e, input logic [1:0] k, input logic t);
    @(posedge i_clk);
    go <= 1'b1;
    ep <= e;
    @(posedge i_clk);
    go <= 1'b0;
    @(posedge i_clk);
    #1 chk({5'h0, o_resp_valid, o_resp_kind}, {5'h1, k});
    chk({7'h0, o_resp_toggle}, {7'h0, t});
    repeat (2) @(posedge i_clk);
  endtask
  initial begin
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    foreach (rows[i]) begin
      wr(ADDR_INDEX, {6'h0, rows[i].ep});
      wr(ADDR_CONFIG, rows[i].cfg);
      wr(ADDR_CTRL_LOW, rows[i].ctrl);
      tok(rows[i].ep, rows[i].kind, 1'b0);
      rd(ADDR_CTRL_LOW, rows[i].rb);
      $display("row %0d done", i);
    end
    rd(ADDR_INT_STAT, 8'h03, 8'h03);
    wr(ADDR_INDEX, 8'h02);
    tok(2'h2, RESP_NAK, 1'b1);
    wr(ADDR_CTRL_LOW, 8'h41);
    rd(ADDR_CTRL_LOW, 8'h03);
    tok(2'h2, RESP_DATA, 1'b0);
    $display("toggle test done");
    wr(ADDR_INDEX, 8'h03);
    wr(ADDR_CONFIG, 8'h00);
    wr(ADDR_CTRL_LOW, 8'h11);
    tok(2'h3, RESP_STALL, 1'b0);
    tok(2'h3, RESP_STALL, 1'b0);
    rd(ADDR_CTRL_LOW, 8'h30, 8'hfd);
    wr(ADDR_CTRL_LOW, 8'h10);
    rd(ADDR_CTRL_LOW, 8'h10, 8'hfd);
    rd(ADDR_INT_STAT, 8'h04, 8'h04);
    $display("stall test done");
    wr(ADDR_INT_STAT, 8'h07);
    wr(ADDR_INT_MASK, 8'h07);
    wr(ADDR_INDEX, 8'h01);
    wr(ADDR_CONFIG, 8'h80);
    wr(ADDR_CTRL_LOW, 8'h01);
    rd(ADDR_CTRL_LOW, 8'h02);
    wr(ADDR_CTRL_LOW, 8'h01);
    wr(ADDR_CTRL_LOW, 8'h08);
    rd(ADDR_CTRL_LOW, 8'h02, 8'hf7);
    chk({7'h0, o_irq}, 8'h01);
    wr(ADDR_CTRL_LOW, 8'h08);
    rd(ADDR_CTRL_LOW, 8'h00, 8'hf7);
    wr(ADDR_INT_MASK, 8'h00);
    rd(ADDR_INT_STAT, 8'h01, 8'h01);
    chk({7'h0, o_irq}, 8'h00);
    wr(ADDR_INT_MASK, 8'h07);
    wr(ADDR_INT_STAT, 8'h01);
    wr(ADDR_CTRL_LOW, 8'h88);
    rd(ADDR_INT_STAT, 8'h00);
    rd(ADDR_CTRL_LOW, 8'h00, 8'h80);
    wr(3'h7, 8'hff);
    rd(3'h7, 8'h00);
    $display("flush test done");
    @(posedge i_clk);
    i_srst <= 1'b1;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    rd(ADDR_INT_STAT, 8'h00);
    wr(ADDR_INDEX, 8'h01);
    rd(ADDR_CTRL_LOW, 8'h00);
    chk({7'h0, o_irq}, 8'h00);
    $display("reset test done");
    final_report();
  end
endmodule
